// [inc/batt_meas_pkg.sv]
`default_nettype none
package batt_meas_pkg;
   localparam int CLK_PERIOD_NS    = 100;
   localparam int SLOT_TIME_MS     = 880;
   localparam int SLOT_CYCLES_DFLT = SLOT_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int OFFSET_PERIOD    = 1024;
   localparam int CONV_CNT_W       = 10;
   localparam int TICK_W           = 32;
   localparam int RAW_W            = 18;
   localparam int SUM_W            = 20;
   localparam int CUR_W            = 16;
   localparam int BIAS_W           = 8;
   localparam int AUX_W            = 16;
   localparam int ACC_W            = 27;
   localparam int SCALE_W          = 36;
   localparam logic signed [CUR_W-1:0]  CUR_MAX    = 16'sh7FFF;
   localparam logic signed [CUR_W-1:0]  CUR_MIN    = 16'sh8000;
   localparam logic signed [SUM_W-1:0]  SUM_HI     = 20'sh07FFF;
   localparam logic signed [SUM_W-1:0]  SUM_LO     = 20'shF8000;
   localparam logic signed [BIAS_W-1:0] BIAS_RESET = 8'sh00;
   localparam logic signed [ACC_W-1:0]  ACC_LIMIT  = 27'sh1FF5D17;
   typedef enum logic [0:0] {
      ST_SLEEP = 1'b0,
      ST_RUN   = 1'b1
   } seq_state_e;
endpackage
`default_nettype wire

// [inc/meas_seq_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface meas_seq_if;
   logic conv_done;
   logic offset_conv;
   logic second_slot;
   modport seq  (output conv_done, output offset_conv, output second_slot);
   modport meas (input conv_done, input offset_conv, input second_slot);
endinterface
`default_nettype wire

// [src/battery_meas_accumulator.sv]
// What this block does
// [R1] Aux slots alternate input A with input B, or with temperature when selected; each measured result refreshes every 1760ms.
// [R2] Divider supply output is driven during each aux input conversion, lagging the slot start by one clock.
// [R3] Temperature result, 0.125 degC per LSB, refreshes every 1760ms when selected.
// [R4] Second aux slot measures temperature only while the temperature select bit is set.
// [R5] Current is positive with the sense pin below ground, negative above.
// [R6] Current result updates every 880ms at the end of each non-offset conversion.
// [R7] Current results clamp to 7FFFh on charge and 8000h on discharge.
// [R8] Every 1024th conversion measures offset; correction applies to the next 1023.
// [R9] Offset conversions leave the current result holding its previous value.
// [R10] Bias is added to raw current; the sum is shown and accumulated.
// [R11] Host may write the bias anytime; later measurements use the new value.
// [R12] Bias is an 8-bit two's complement value in 25 microvolt steps.
// [R13] Bias lives in retained storage with a default of 00h.
// [R14] Charge counter adds each unblanked corrected current at the end of each non-offset conversion, spanning 204.8mVh.
// [R15] Accumulated charge is scaled by the capacity factor for relative capacity.
// [R16] Currents below the blanking threshold are not accumulated; the counter holds.
// [R17] Measurements run only in active mode; register access works in sleep.
// [R18] Charge counter saturates at its range limits instead of wrapping.
`timescale 1ns/100ps
`default_nettype none
module battery_meas_accumulator import batt_meas_pkg::*; #(
   parameter int SLOT_CYCLES = SLOT_CYCLES_DFLT
) (
   // Clock and reset.
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_b,
   // Mode and configuration.
   input  wire logic                     i_active,
   input  wire logic                     i_internal_temp_select,
   input  wire logic [7:0]               i_blank_threshold,
   input  wire logic [7:0]               i_capacity_factor,
   // Converter samples.
   input  wire logic signed [RAW_W-1:0]  i_sense_pin,
   input  wire logic signed [AUX_W-1:0]  i_aux_input_a,
   input  wire logic signed [AUX_W-1:0]  i_aux_input_b,
   input  wire logic signed [AUX_W-1:0]  i_temp_sensor,
   // Bias register access.
   input  wire logic                     i_bias_wr,
   input  wire logic signed [BIAS_W-1:0] i_bias_wdata,
   output logic signed [BIAS_W-1:0]      o_current_offset_bias,
   // Results.
   output logic signed [CUR_W-1:0]       o_current,
   output logic signed [AUX_W-1:0]       o_aux_a,
   output logic signed [AUX_W-1:0]       o_aux_b,
   output logic signed [AUX_W-1:0]       o_temperature,
   output logic signed [ACC_W-1:0]       o_charge_accumulator,
   output logic signed [SCALE_W-1:0]     o_scaled_charge,
   // Divider supply.
   output logic                          o_divider_supply_out
);
   meas_seq_if seq_bus ();

   meas_sequencer #(
      .SLOT_CYCLES (SLOT_CYCLES)
   ) u_seq (
      .i_clk    (i_clk),
      .i_rst_b  (i_rst_b),
      .i_active (i_active),
      .seq      (seq_bus.seq)
   );

   logic signed [BIAS_W-1:0]  bias_r, bias_nxt;
   logic signed [RAW_W-1:0]   offset_r, offset_nxt;
   logic signed [CUR_W-1:0]   cur_r, cur_nxt;
   logic signed [AUX_W-1:0]   aux_a_r, aux_a_nxt;
   logic signed [AUX_W-1:0]   aux_b_r, aux_b_nxt;
   logic signed [AUX_W-1:0]   temp_r, temp_nxt;
   logic signed [ACC_W-1:0]   acc_r, acc_nxt;
   logic signed [SCALE_W-1:0] scaled_r, scaled_nxt;
   logic                      div_r, div_nxt;
   logic signed [SUM_W-1:0]   cur_sum;
   logic signed [CUR_W-1:0]   cur_clamped;
   logic [CUR_W:0]            cur_mag;
   logic                      blank;
   logic signed [ACC_W:0]     acc_sum;
   logic                      meas_done;

   assign meas_done = seq_bus.conv_done && !seq_bus.offset_conv;

   always_comb begin
      cur_sum = SUM_W'(offset_r) - SUM_W'(i_sense_pin) + SUM_W'(bias_r); // [R5] [R8] [R10]
      if (cur_sum > SUM_HI) begin // [R7]
         cur_clamped = CUR_MAX;
      end else if (cur_sum < SUM_LO) begin
         cur_clamped = CUR_MIN;
      end else begin
         cur_clamped = cur_sum[CUR_W-1:0];
      end
      cur_mag = cur_clamped[CUR_W-1] ? (CUR_W+1)'(-cur_clamped) : (CUR_W+1)'(cur_clamped);
      blank   = cur_mag < {9'h000, i_blank_threshold}; // [R16]
      acc_sum = (ACC_W+1)'(acc_r) + (ACC_W+1)'(cur_clamped); // [R14]
   end

   always_comb begin
      bias_nxt   = bias_r;
      offset_nxt = offset_r;
      cur_nxt    = cur_r;
      aux_a_nxt  = aux_a_r;
      aux_b_nxt  = aux_b_r;
      temp_nxt   = temp_r;
      acc_nxt    = acc_r;
      if (i_bias_wr) begin // [R11] [R12]
         bias_nxt = i_bias_wdata;
      end
      if (seq_bus.conv_done && seq_bus.offset_conv) begin // [R8] [R9]
         offset_nxt = i_sense_pin;
      end
      if (meas_done) begin // [R6] [R10]
         cur_nxt = cur_clamped;
         if (!blank) begin // [R16]
            if (acc_sum > (ACC_W+1)'(ACC_LIMIT)) begin // [R18]
               acc_nxt = ACC_LIMIT;
            end else if (acc_sum < -(ACC_W+1)'(ACC_LIMIT)) begin
               acc_nxt = -ACC_LIMIT;
            end else begin
               acc_nxt = acc_sum[ACC_W-1:0]; // [R14]
            end
         end
      end
      // The slot parity has already moved on when the done pulse arrives.
      if (seq_bus.conv_done) begin
         if (seq_bus.second_slot) begin // [R1]
            aux_a_nxt = i_aux_input_a;
         end else if (i_internal_temp_select) begin // [R3] [R4]
            temp_nxt = i_temp_sensor;
         end else begin
            aux_b_nxt = i_aux_input_b;
         end
      end
      scaled_nxt = SCALE_W'(acc_r) * SCALE_W'(signed'({1'b0, i_capacity_factor})); // [R15]
      div_nxt    = i_active && (!seq_bus.second_slot || !i_internal_temp_select); // [R2]
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         bias_r   <= BIAS_RESET; // [R13]
         offset_r <= '0;
         cur_r    <= '0;
         aux_a_r  <= '0;
         aux_b_r  <= '0;
         temp_r   <= '0;
         acc_r    <= '0;
         scaled_r <= '0;
         div_r    <= 1'b0;
      end else begin
         bias_r   <= bias_nxt;
         offset_r <= offset_nxt;
         cur_r    <= cur_nxt;
         aux_a_r  <= aux_a_nxt;
         aux_b_r  <= aux_b_nxt;
         temp_r   <= temp_nxt;
         acc_r    <= acc_nxt;
         scaled_r <= scaled_nxt;
         div_r    <= div_nxt;
      end
   end

   assign o_current_offset_bias = bias_r;
   assign o_current             = cur_r;
   assign o_aux_a               = aux_a_r;
   assign o_aux_b               = aux_b_r;
   assign o_temperature         = temp_r;
   assign o_charge_accumulator  = acc_r;
   assign o_scaled_charge       = scaled_r;
   assign o_divider_supply_out  = div_r;

   a_bias_write_taken: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R11]
      i_bias_wr |=> (bias_r == $past(i_bias_wdata)))
      else $error("Bias write not taken.");
   a_clamp_high: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R7]
      (meas_done && cur_sum > SUM_HI) |=> (cur_r == CUR_MAX))
      else $error("Charge overrange not clamped.");
   a_clamp_low: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R7]
      (meas_done && cur_sum < SUM_LO) |=> (cur_r == CUR_MIN))
      else $error("Discharge overrange not clamped.");
   a_offset_holds_cur: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R9]
      (seq_bus.conv_done && seq_bus.offset_conv) |=> $stable(cur_r))
      else $error("Current changed on offset conversion.");
   a_cur_update_time: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
      $changed(cur_r) |-> $past(meas_done))
      else $error("Current changed outside conversion end.");
   a_blank_holds_acc: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R16]
      (meas_done && blank) |=> $stable(acc_r))
      else $error("Blanked current was accumulated.");
   a_acc_in_range: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R18]
      (acc_r <= ACC_LIMIT) && (acc_r >= -ACC_LIMIT))
      else $error("Charge counter out of range.");
   a_divider_on_aux: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R2]
      (seq_bus.conv_done && (seq_bus.second_slot || !$past(i_internal_temp_select))) |-> div_r)
      else $error("Divider off during aux conversion.");
   a_temp_slot: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
      (seq_bus.conv_done && !seq_bus.second_slot && i_internal_temp_select)
      |=> (temp_r == $past(i_temp_sensor)) && $stable(aux_b_r))
      else $error("Temperature slot misrouted.");
   a_aux_a_slot: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R1]
      (seq_bus.conv_done && seq_bus.second_slot) |=> (aux_a_r == $past(i_aux_input_a)))
      else $error("First aux slot misrouted.");
   a_aux_b_slot: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
      (seq_bus.conv_done && !seq_bus.second_slot && !i_internal_temp_select)
      |=> (aux_b_r == $past(i_aux_input_b)) && $stable(temp_r))
      else $error("Second aux slot misrouted.");
   a_offset_capture: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R8]
      (seq_bus.conv_done && seq_bus.offset_conv) |=> (offset_r == $past(i_sense_pin)))
      else $error("Offset sample not captured.");
   a_acc_saturate: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R18]
      (meas_done && !blank && acc_sum > (ACC_W+1)'(ACC_LIMIT)) |=> (acc_r == ACC_LIMIT))
      else $error("Charge counter did not saturate.");
   a_bias_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R11]
      !i_bias_wr |=> $stable(bias_r))
      else $error("Bias changed without a write.");
   a_divider_sleep: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R17]
      !i_active |=> !div_r)
      else $error("Divider driven while asleep.");

   c_offset_conv: cover property (@(posedge i_clk) seq_bus.conv_done && seq_bus.offset_conv);
   c_blanked: cover property (@(posedge i_clk) meas_done && blank);
   c_clamp_hi: cover property (@(posedge i_clk) meas_done && cur_sum > SUM_HI);
   c_temp_slot: cover property (@(posedge i_clk)
      seq_bus.conv_done && !seq_bus.second_slot && i_internal_temp_select);
   c_acc_limit: cover property (@(posedge i_clk) acc_r == ACC_LIMIT);
endmodule // battery_meas_accumulator
`default_nettype wire

// [src/meas_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module meas_sequencer import batt_meas_pkg::*; #(
   parameter int SLOT_CYCLES = SLOT_CYCLES_DFLT
) (
   // Clock and reset.
   input  wire logic  i_clk,
   input  wire logic  i_rst_b,
   // Mode.
   input  wire logic  i_active,
   // Conversion events.
   meas_seq_if.seq    seq
);
   seq_state_e            state_r, state_nxt;
   logic [TICK_W-1:0]     tick_r, tick_nxt;
   logic [CONV_CNT_W-1:0] conv_r, conv_nxt;
   logic                  done_r, done_nxt;
   logic                  second_r, second_nxt;
   logic                  off_r, off_nxt;

   always_comb begin
      state_nxt  = state_r;
      tick_nxt   = tick_r;
      conv_nxt   = conv_r;
      done_nxt   = 1'b0;
      second_nxt = second_r;
      off_nxt    = 1'b0;
      case (state_r)
         ST_SLEEP: begin
            tick_nxt = '0;
            if (i_active) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!i_active) begin // [R17]
               state_nxt = ST_SLEEP;
               tick_nxt  = '0;
            end else if (tick_r == TICK_W'(SLOT_CYCLES - 1)) begin // [R6]
               tick_nxt   = '0;
               done_nxt   = 1'b1;
               conv_nxt   = conv_r + 1'b1; // [R8]
               off_nxt    = (conv_r == CONV_CNT_W'(OFFSET_PERIOD - 1)); // [R8]
               second_nxt = !second_r; // [R1]
            end else begin
               tick_nxt = tick_r + 1'b1;
            end
         end
         default: begin
            state_nxt = ST_SLEEP;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_r  <= ST_SLEEP;
         tick_r   <= '0;
         conv_r   <= '0;
         done_r   <= 1'b0;
         second_r <= 1'b0;
         off_r    <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         tick_r   <= tick_nxt;
         conv_r   <= conv_nxt;
         done_r   <= done_nxt;
         second_r <= second_nxt;
         off_r    <= off_nxt;
      end
   end

   assign seq.conv_done   = done_r;
   assign seq.offset_conv = off_r; // [R8]
   assign seq.second_slot = second_r;

   a_offset_period: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R8]
      (done_r && seq.offset_conv) |=> (conv_r == '0))
      else $error("Offset conversion not followed by count restart.");
   a_sleep_no_conv: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R17]
      !i_active |=> !done_r)
      else $error("Conversion completed while asleep.");
endmodule // meas_sequencer
`default_nettype wire

// [test/battery_meas_accumulator_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module battery_meas_accumulator_bench import batt_meas_pkg::*; ;
   localparam int N = 8;
   logic                      i_clk, i_rst_b, act, tsel, bias_wr, divider;
   logic [7:0]                thr, cap;
   logic signed [RAW_W-1:0]   sense;
   logic signed [AUX_W-1:0]   ain_a, ain_b, tsen, aux_a, aux_b, temp;
   logic signed [BIAS_W-1:0]  bias_wdata, bias;
   logic signed [CUR_W-1:0]   cur;
   logic signed [ACC_W-1:0]   acc;
   logic signed [SCALE_W-1:0] scaled;
   logic signed [7:0]         bw [3] = '{8'sh7F, 8'sh80, 8'sh05};
   longint                    sv [8] = '{100, -200, 3, -3, -40000, 40000, 12, 0};
   longint                    e_cur, e_acc, e_off, e_bias, e_a, e_b, e_t, stim;
   int                        num_errors, comparisons, idx;

   bias_host_model host_u (.i_clk(i_clk), .o_bias_wr(bias_wr), .o_bias_wdata(bias_wdata));

   battery_meas_accumulator #(.SLOT_CYCLES(N)) dut_u (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_active(act), .i_internal_temp_select(tsel),
      .i_blank_threshold(thr), .i_capacity_factor(cap), .i_sense_pin(sense),
      .i_aux_input_a(ain_a), .i_aux_input_b(ain_b), .i_temp_sensor(tsen),
      .i_bias_wr(bias_wr), .i_bias_wdata(bias_wdata), .o_current_offset_bias(bias),
      .o_current(cur), .o_aux_a(aux_a), .o_aux_b(aux_b), .o_temperature(temp),
      .o_charge_accumulator(acc), .o_scaled_charge(scaled), .o_divider_supply_out(divider));

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic check_all();
      check("bias", bias, e_bias);
      check("current", cur, e_cur);
      check("aux_a", aux_a, e_a);
      check("aux_b", aux_b, e_b);
      check("temperature", temp, e_t);
      check("charge", acc, e_acc);
      check("scaled", scaled, e_acc * cap);
      check("divider", divider, act && (idx[0] == 1'b0 || !tsel));
   endtask

   // Drives one conversion slot, mirrors its effect and compares all results mid next slot.
   task automatic do_slot(input longint s, input logic ts, input logic wr, input logic [7:0] nb);
      longint raw;
      longint t;
      t     = thr;
      sense = s[RAW_W-1:0];
      tsel  = ts;
      ain_a = 16'(idx + 32'h1200);
      ain_b = 16'(32'h5000 - idx);
      tsen  = 16'(-idx);
      if (wr) begin
         host_u.write_bias(nb);
         e_bias = longint'($signed(nb));
         repeat (N - 2) @(negedge i_clk);
      end else begin
         repeat (N) @(negedge i_clk);
      end
      if (idx % 1024 == 1023) begin
         e_off = s;
      end else begin
         raw   = e_off - s + e_bias;
         e_cur = raw > 32767 ? 32767 : (raw < -32768 ? -32768 : raw);
         if (!(e_cur < t && -e_cur < t)) begin
            e_acc += e_cur;
            if (e_acc > ACC_LIMIT) begin
               e_acc = ACC_LIMIT;
            end else if (e_acc < -ACC_LIMIT) begin
               e_acc = -ACC_LIMIT;
            end
         end
      end
      if (idx[0] == 1'b0) begin
         e_a = ain_a;
      end else if (ts) begin
         e_t = tsen;
      end else begin
         e_b = ain_b;
      end
      idx++;
      check_all();
   endtask

   task automatic complete_run();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   initial begin
      #(100 * 20000);
      num_errors++;
      complete_run();
   end

   initial begin
      {i_rst_b, act, tsel, sense, ain_a, ain_b, tsen} = '0;
      thr = 8'h0A;
      cap = 8'h03;
      {e_cur, e_acc, e_off, e_bias, e_a, e_b, e_t} = '0;
      idx = 0;
      num_errors = 0;
      comparisons = 0;
      repeat (20) @(negedge i_clk);
      i_rst_b = 1'b1;
      @(negedge i_clk);
      check_all();
      foreach (bw[i]) begin
         host_u.write_bias(bw[i]);
         e_bias = bw[i];
         check_all();
      end
      act = 1'b1;
      repeat (N / 2) @(negedge i_clk);
      foreach (sv[i]) begin
         do_slot(sv[i], i[1], i == 3, 8'hF8);
      end
      act = 1'b0;
      sense = 18'sh00100;
      repeat (3 * N) @(negedge i_clk);
      host_u.write_bias(8'sh10);
      e_bias = 16;
      check_all();
      act = 1'b1;
      repeat (N / 2) @(negedge i_clk);
      while (idx < 1040) begin
         stim = idx < 1034 ? -40000 : (idx % 5 - 2) * 40;
         do_slot(idx == 1023 ? 120 : stim, 1'b0, 1'b0, 8'h00);
      end
      complete_run();
   end
endmodule // battery_meas_accumulator_bench
`default_nettype wire

// [test/bias_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bias_host_model import batt_meas_pkg::*; (
   // Clock.
   input  wire logic                i_clk,
   // Bias write port.
   output logic                     o_bias_wr,
   output logic signed [BIAS_W-1:0] o_bias_wdata
);
   initial begin
      o_bias_wr    = 1'b0;
      o_bias_wdata = 8'sh00;
   end
   // Writes one bias word for one edge, then lets one more edge pass with the strobe low.
   task automatic write_bias(input logic signed [BIAS_W-1:0] v);
      o_bias_wr    = 1'b1;
      o_bias_wdata = v;
      @(negedge i_clk);
      o_bias_wr    = 1'b0;
      o_bias_wdata = ~v;
      @(negedge i_clk);
   endtask
endmodule // bias_host_model
`default_nettype wire
